/* File: verilog/slvm_top.sv */
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module slvm_top
  import slvm_pkg::*;
#(
  parameter int FLAG_DELAY_CYC = SLVM_FLAG_DELAY_CYC,
  parameter int SETTLE_DELAY_CYC = SLVM_SETTLE_DELAY_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [SLVM_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic i_below_threshold,
  input wire logic i_stack_full,
  input wire logic i_irq_serviced,
  input wire logic i_sleeping,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_detector_on,
  output logic [SLVM_THR_W-1:0] o_threshold_select,
  output logic o_vector_request,
  output logic o_wake,
  output logic o_irq
);
  ////////////////////////////////////////////////////////////////////////
  // state
  logic en_q;
  logic en_d;
  logic [SLVM_THR_W-1:0] thr_q;
  logic [SLVM_THR_W-1:0] thr_d;
  logic ind_q;
  logic ind_d;
  logic lvf_q;
  logic lvf_d;
  logic lve_q;
  logic lve_d;
  logic mfe_q;
  logic mfe_d;
  logic gie_q;
  logic gie_d;
  logic mff_q;
  logic mff_d;
  logic [SLVM_EV_W-1:0] sts_q;
  logic [SLVM_EV_W-1:0] sts_d;
  logic [SLVM_EV_W-1:0] msk_q;
  logic [SLVM_EV_W-1:0] msk_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic vec_q;
  logic vec_d;
  logic wake_q;
  logic wake_d;
  logic irq_q;
  logic irq_d;
  logic settled;
  logic flag_due;
  logic flag_due_q;
  logic lvf_rise;

  ////////////////////////////////////////////////////////////////////////
  // delays
  // settle delay masks comparator chatter right after power-up
  slvm_delay u_settle (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_level(en_q),
    .i_count(SLVM_CNT_W'(SETTLE_DELAY_CYC)),
    .o_done(settled)
  );

  slvm_delay u_flag (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_level(ind_q),
    .i_count(SLVM_CNT_W'(FLAG_DELAY_CYC)),
    .o_done(flag_due)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus and control
  logic req;
  logic wr_hit;
  logic rd_hit;
  logic sts_rd;
  logic flag_set;
  logic [SLVM_EV_W-1:0] ev;
  logic [7:0] rd_byte;
  logic wait_q;
  logic wait_d;

  // one access at a time: nothing is taken while an answer stands
  assign req = (i_avs_read | i_avs_write) & ~ack_q;
  // a write without its low byte lane does nothing
  assign wr_hit = req & i_avs_write & i_avs_byteenable[0];
  assign rd_hit = req & i_avs_read;
  assign sts_rd = rd_hit & (i_avs_address == SLVM_ADDR_IRQ_STATUS);
  // one flag set per completed delay: edge of done
  assign flag_set = flag_due & ~flag_due_q;
  // any low-to-high step of the flag, from hardware or software
  assign lvf_rise = lvf_d & ~lvf_q;

  ////////////////////////////////////////////////////////////////////////
  // register read mux
  // only the low byte carries register bits; the rest reads zero
  always_comb begin
    rd_byte = '0;
    unique case (i_avs_address)
      SLVM_ADDR_CONTROL: begin
        rd_byte[SLVM_IND_BIT] = ind_q;
        rd_byte[SLVM_EN_BIT] = en_q;
        rd_byte[SLVM_THR_LSB +: SLVM_THR_W] = thr_q;
      end
      SLVM_ADDR_FLAGS: begin
        rd_byte[SLVM_LVF_BIT] = lvf_q;
        rd_byte[SLVM_LVE_BIT] = lve_q;
        rd_byte[SLVM_MFE_BIT] = mfe_q;
        rd_byte[SLVM_GIE_BIT] = gie_q;
        rd_byte[SLVM_MFF_BIT] = mff_q;
      end
      SLVM_ADDR_IRQ_STATUS: rd_byte[SLVM_EV_W-1:0] = sts_q;
      SLVM_ADDR_IRQ_MASK: rd_byte[SLVM_EV_W-1:0] = msk_q;
      // unmapped words read as zero
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: answer one cycle after taking, low for one cycle
  always_comb begin
    ack_d = req;
    // waitrequest is its own flop so the pin comes straight from one
    wait_d = ~req;
    rdata_d = rdata_q;
    // readdata holds until the next read is taken
    if (rd_hit) begin
      rdata_d = 32'(rd_byte);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      ack_q <= ack_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // detector control
  always_comb begin
    en_d = en_q;
    // threshold code goes straight out to the comparator reference
    thr_d = thr_q;
    // indication only valid when detector running and settled
    ind_d = en_q & settled & i_below_threshold;
    // bits 7, 6 and 3 have no storage, so writes to them vanish
    if (wr_hit && (i_avs_address == SLVM_ADDR_CONTROL)) begin
      en_d = i_avs_writedata[SLVM_EN_BIT];
      thr_d = i_avs_writedata[SLVM_THR_LSB +: SLVM_THR_W];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      en_q <= SLVM_CONTROL_RESET[SLVM_EN_BIT];
      thr_q <= SLVM_CONTROL_RESET[SLVM_THR_LSB +: SLVM_THR_W];
      ind_q <= SLVM_CONTROL_RESET[SLVM_IND_BIT];
    end else begin
      en_q <= en_d;
      thr_q <= thr_d;
      ind_q <= ind_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request flag and enables
  // all five bits read back as written, unless hardware moves them
  always_comb begin
    lvf_d = lvf_q;
    lve_d = lve_q;
    mfe_d = mfe_q;
    gie_d = gie_q;
    mff_d = mff_q;
    if (wr_hit && (i_avs_address == SLVM_ADDR_FLAGS)) begin
      lvf_d = i_avs_writedata[SLVM_LVF_BIT];
      lve_d = i_avs_writedata[SLVM_LVE_BIT];
      mfe_d = i_avs_writedata[SLVM_MFE_BIT];
      gie_d = i_avs_writedata[SLVM_GIE_BIT];
      mff_d = i_avs_writedata[SLVM_MFF_BIT];
    end
    // servicing clears only the multi-function flag and global enable
    if (i_irq_serviced) begin
      mff_d = 1'b0;
      gie_d = 1'b0;
    end
    // hardware set wins over software clear; also works while asleep
    if (flag_set) begin
      lvf_d = 1'b1;
      mff_d = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lvf_q <= 1'b0;
      lve_q <= 1'b0;
      mfe_q <= 1'b0;
      gie_q <= 1'b0;
      mff_q <= 1'b0;
      flag_due_q <= 1'b0;
    end else begin
      lvf_q <= lvf_d;
      lve_q <= lve_d;
      mfe_q <= mfe_d;
      gie_q <= gie_d;
      mff_q <= mff_d;
      flag_due_q <= flag_due;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event status, mask and level interrupt
  always_comb begin
    // mask bits only gate the pin, never the status bits
    msk_d = msk_q;
    sts_d = sts_q;
    ev = '0;
    ev[SLVM_EV_FLAG] = lvf_rise;
    // the wake event marks a flag raise seen while the core sleeps
    ev[SLVM_EV_WAKE] = lvf_rise & i_sleeping;
    if (wr_hit && (i_avs_address == SLVM_ADDR_IRQ_MASK)) begin
      msk_d = i_avs_writedata[SLVM_EV_W-1:0];
    end
    // clear first, so an event in the clearing cycle is kept
    if (sts_rd) begin
      sts_d = '0;
    end
    sts_d = sts_d | ev;
    // from next values, so the pin follows its status bits with no lag
    irq_d = |(sts_d & msk_d);
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sts_q <= '0;
      msk_q <= '0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      msk_q <= msk_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vector request and wake pulse
  always_comb begin
    // one cycle late: the stack input is sampled with the enables
    vec_d = gie_q & lve_q & mfe_q & lvf_q & ~i_stack_full;
    // wake ignores the lve, mfe and gie enables; the detector enable gates only the hardware flag set
    wake_d = lvf_rise;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      vec_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      vec_q <= vec_d;
      wake_q <= wake_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_detector_on = en_q;
  assign o_threshold_select = thr_q;
  assign o_vector_request = vec_q;
  assign o_wake = wake_q;
  assign o_irq = irq_q;
endmodule

/* File: verilog/slvm_pkg.sv */
package slvm_pkg;
  // register map (word addresses on the avalon bus, byte address = 4*index)
  localparam logic [3:0] SLVM_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] SLVM_ADDR_FLAGS = 4'h1;
  localparam logic [3:0] SLVM_ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] SLVM_ADDR_IRQ_MASK = 4'h3;
  localparam int SLVM_ADDR_W = 4;

  // control register layout
  localparam int SLVM_THR_LSB = 0;
  localparam int SLVM_THR_W = 3;
  localparam int SLVM_EN_BIT = 4;
  localparam int SLVM_IND_BIT = 5;
  localparam logic [7:0] SLVM_CONTROL_RESET = 8'h00;

  // flags register layout
  localparam int SLVM_LVF_BIT = 0;
  localparam int SLVM_LVE_BIT = 1;
  localparam int SLVM_MFE_BIT = 2;
  localparam int SLVM_GIE_BIT = 3;
  localparam int SLVM_MFF_BIT = 4;

  // interrupt status layout
  localparam int SLVM_EV_FLAG = 0;
  localparam int SLVM_EV_WAKE = 1;
  localparam int SLVM_EV_W = 2;

  // timing
  localparam int SLVM_CLK_HZ = 40_000_000;
  localparam int SLVM_FLAG_DELAY_US = 15;
  localparam int SLVM_SETTLE_DELAY_US = 15;
  localparam int SLVM_FLAG_DELAY_CYC =
    SLVM_FLAG_DELAY_US * (SLVM_CLK_HZ / 1_000_000);
  localparam int SLVM_SETTLE_DELAY_CYC =
    SLVM_SETTLE_DELAY_US * (SLVM_CLK_HZ / 1_000_000);
  localparam int SLVM_CNT_W = 16;
endpackage

/* File: verilog/slvm_delay.sv */
`timescale 1ns/1ps
// counts consecutive cycles of i_level; o_done high once the count is met
module slvm_delay
  import slvm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_level,
  input wire logic [SLVM_CNT_W-1:0] i_count,
  output logic o_done
);
  logic [SLVM_CNT_W-1:0] cnt_q;
  logic [SLVM_CNT_W-1:0] cnt_d;
  logic done_q;
  logic done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (!i_level) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (cnt_q < i_count) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
endmodule

/* File: verification/slvm_chk.sv */
`timescale 1ns/1ps
module slvm_chk
  import slvm_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [SLVM_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic i_stack_full,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_detector_on,
  input wire logic [SLVM_THR_W-1:0] o_threshold_select,
  input wire logic o_vector_request,
  input wire logic o_wake
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_answer_next: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
  a_unmapped_zero: assert property (!o_avs_waitrequest && $past(i_avs_read)
    && $past(i_avs_address) > 4'h3 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_spare_zero: assert property (!o_avs_waitrequest && $past(i_avs_read) &&
    $past(i_avs_address) == SLVM_ADDR_CONTROL |->
    {o_avs_readdata[31:6], o_avs_readdata[3]} == 27'h0)
    else $error("spare control bits set");
  a_thr_by_write: assert property (!$stable(o_threshold_select) |->
    $past(i_avs_write)) else $error("threshold moved alone");
  a_en_by_write: assert property (!$stable(o_detector_on) |->
    $past(i_avs_write)) else $error("enable moved alone");
  a_stack_blocks: assert property (i_stack_full |=> !o_vector_request)
    else $error("vector with full stack");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  c_wake: cover property (o_wake);
  c_vector: cover property (o_vector_request);
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule
bind slvm_top slvm_chk i_slvm_chk (.i_mclk, .i_rst, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_stack_full, .o_avs_readdata,
  .o_avs_waitrequest, .o_detector_on, .o_threshold_select,
  .o_vector_request, .o_wake);

/* File: verification/slvm_top_test.sv */
`timescale 1ns/1ps
module slvm_top_test
  import slvm_pkg::*;
;
  logic i_mclk, i_rst, i_avs_read, i_avs_write, i_below_threshold;
  logic i_stack_full, i_irq_serviced, i_sleeping, o_avs_waitrequest;
  logic o_detector_on, o_vector_request, o_wake, o_irq;
  logic [3:0] i_avs_address, i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [2:0] o_threshold_select;
  logic [7:0] q;
  int num_errors, checked;
  // short delays keep the run brief
  slvm_top #(.FLAG_DELAY_CYC(4), .SETTLE_DELAY_CYC(4)) i_slvm_top (.i_mclk,
    .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .i_below_threshold, .i_stack_full, .i_irq_serviced,
    .i_sleeping, .o_avs_readdata, .o_avs_waitrequest, .o_detector_on,
    .o_threshold_select, .o_vector_request, .o_wake, .o_irq);
  initial begin
    i_mclk = 0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp(input string s, input logic [7:0] e, input logic [7:0] v);
    checked++;
    if (v !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", s, e, v);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata[7:0];
    i_avs_read <= 0;
    i_avs_write <= 0;
    if (n >= 50) begin
      num_errors++;
      give_verdict;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    acc(1, a, d, 4'h1);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string s);
    acc(0, a, 8'h00, 4'hf);
    cmp(s, e, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(SLVM_ADDR_CONTROL, 8'h00, "ctrl_reset");
    for (int c = 0; c < 8; c++) begin
      wr(SLVM_ADDR_CONTROL, 8'hd8 | 8'(c));
      rd(SLVM_ADDR_CONTROL, 8'h10 | 8'(c), "ctrl");
      cmp("thr", 8'(c), {5'h0, o_threshold_select});
      cmp("en", 8'h01, {7'h0, o_detector_on});
    end
    acc(1, SLVM_ADDR_CONTROL, 8'h00, 4'h0);
    rd(SLVM_ADDR_CONTROL, 8'h17, "ctrl_no_be");
    rd(4'h9, 8'h00, "unmapped");
  endtask
  task t_detect;
    int n;
    wr(SLVM_ADDR_CONTROL, 8'h10);
    wr(SLVM_ADDR_IRQ_MASK, 8'h03);
    wr(SLVM_ADDR_FLAGS, 8'h00);
    repeat (10) @(posedge i_mclk);
    i_sleeping <= 1;
    i_below_threshold <= 1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wake !== 1'b1 && n < 100);
    cmp("wake_late", 8'h01, {7'h0, n > 4 && n < 100});
    if (n >= 100) give_verdict;
    repeat (2) @(posedge i_mclk);
    cmp("irq", 8'h01, {7'h0, o_irq});
    rd(SLVM_ADDR_CONTROL, 8'h30, "ctrl_ind");
    rd(SLVM_ADDR_IRQ_STATUS, 8'h03, "status");
    rd(SLVM_ADDR_IRQ_STATUS, 8'h00, "status_clr");
    repeat (2) @(posedge i_mclk);
    cmp("irq_clr", 8'h00, {7'h0, o_irq});
  endtask
  task t_vector;
    wr(SLVM_ADDR_FLAGS, 8'h0f);
    repeat (3) @(posedge i_mclk);
    cmp("vec", 8'h01, {7'h0, o_vector_request});
    i_stack_full <= 1;
    repeat (3) @(posedge i_mclk);
    cmp("vec_full", 8'h00, {7'h0, o_vector_request});
    i_stack_full <= 0;
    i_irq_serviced <= 1;
    @(posedge i_mclk);
    i_irq_serviced <= 0;
    rd(SLVM_ADDR_FLAGS, 8'h07, "flags_srv");
    cmp("vec_srv", 8'h00, {7'h0, o_vector_request});
  endtask
  task t_block;
    int w;
    w = 0;
    // supply back above the level first, so the next drop is a new one
    i_below_threshold <= 0;
    repeat (4) @(posedge i_mclk);
    wr(SLVM_ADDR_FLAGS, 8'h01);
    i_below_threshold <= 1;
    repeat (20) begin
      @(posedge i_mclk);
      w += int'(o_wake === 1'b1);
    end
    cmp("no_wake", 8'h00, 8'(w));
    wr(SLVM_ADDR_CONTROL, 8'h00);
    rd(SLVM_ADDR_CONTROL, 8'h00, "ctrl_off");
    cmp("en_off", 8'h00, {7'h0, o_detector_on});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {i_avs_read, i_avs_write, i_below_threshold, i_stack_full} = '0;
    {i_irq_serviced, i_sleeping, i_avs_address, i_avs_byteenable} = '0;
    i_avs_writedata = '0;
    num_errors = 0;
    checked = 0;
    i_rst = 1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 0;
    t_regs;
    t_detect;
    t_vector;
    t_block;
    give_verdict;
  end
endmodule
